/* File: dv/pidsr_link_model.sv */
`timescale 1ns/1ps
// far side of the isolation link: one strobed update on request, bus scrambled in between
module pidsr_link_model (
	input  wire logic                        clk,       // system clock
	input  wire logic                        send,      // bench asks for one update
	input  wire pidsr_pkg::pidsr_secondary_s val,       // value to deliver
	output pidsr_pkg::pidsr_secondary_s      sec_in,    // link data
	output logic                             sec_valid  // one-cycle update strobe
);
	initial begin
		sec_in = '0;
		sec_valid = 1'b0;
	end
	// data only counts with the strobe; toggling it otherwise exposes a mirror that follows the bus
	always @(posedge clk) begin
		sec_valid <= send;
		sec_in <= send ? val : pidsr_pkg::pidsr_secondary_s'(~sec_in);
	end
endmodule

/* File: dv/tb_pidsr_regs.sv */
`timescale 1ns/1ps
module tb_pidsr_regs;
	localparam logic [11:0] VER = 12'h3C6; // arbitrary version code
	logic                        clk, resetn, rd_req, wr_req, msg_rejected, sec_valid, send, rd_valid, rd_hit;
	logic [7:0]                  addr, primary_err;
	logic [15:0]                 wdata, rdata, st;
	pidsr_pkg::pidsr_secondary_s sec_in, val;
	int                          error_cnt, checks_done, cycles;

	pidsr_regs #(.CHIP_VERSION(VER)) u_pidsr_regs (.clk(clk), .resetn(resetn), .rd_req(rd_req), .wr_req(wr_req),
		.addr(addr), .wdata(wdata), .msg_rejected(msg_rejected), .primary_err(primary_err), .sec_valid(sec_valid),
		.sec_in(sec_in), .rd_valid(rd_valid), .rd_hit(rd_hit), .rdata(rdata));
	pidsr_link_model u_pidsr_link_model (.clk(clk), .send(send), .val(val), .sec_in(sec_in), .sec_valid(sec_valid));

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// hang guard, far above the roughly 110 cycles the sequence needs
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			error_cnt = error_cnt + 1;
			report_and_stop();
		end
	end
	task automatic report_and_stop();
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// trailer: rejected flag then odd parity over the whole word
	function automatic logic [15:0] fmt(input logic [15:0] pl, input logic rej);
		fmt = {pl[15:2], rej, ~^{pl[15:2], rej}};
	endfunction
	// one read from a falling edge: answer checked in the one cycle the valid pulse stands, then an idle edge
	task automatic rd(input logic [7:0] a, input logic rej, input logic hit, input logic [15:0] pl);
		rd_req = 1'b1;
		addr = a;
		msg_rejected = rej;
		@(negedge clk);
		rd_req = 1'b0;
		chk({14'h0, rd_valid, rd_hit}, {14'h0, 1'b1, hit});
		chk(rdata, fmt(hit ? pl : 16'h0000, rej));
		@(negedge clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		wr_req = 1'b1;
		addr = a;
		wdata = d;
		@(negedge clk);
		wr_req = 1'b0;
		@(negedge clk);
	endtask
	// link update plus error pattern; returns once the mirror has taken it
	task automatic upd(input logic [5:0] v, input logic [7:0] e);
		val = pidsr_pkg::pidsr_secondary_s'(v);
		primary_err = e;
		send = 1'b1;
		@(negedge clk);
		send = 1'b0;
		@(negedge clk);
	endtask

	// main sequence
	initial begin
		resetn = 1'b0;
		rd_req = 1'b0;
		wr_req = 1'b0;
		addr = 8'h00;
		wdata = 16'h0000;
		msg_rejected = 1'b0;
		primary_err = 8'h00;
		send = 1'b0;
		val = '0;
		error_cnt = 0;
		checks_done = 0;
		cycles = 0;
		repeat (4) @(negedge clk);
		resetn = 1'b1;
		rd(8'h01, 1'b0, 1'b1, 16'h0800);
		rd(8'h00, 1'b1, 1'b1, {VER, 4'h0});
		rd(8'h00, 1'b0, 1'b1, {VER, 4'h0});
		for (int i = 0; i < 8; i++) begin
			upd({i[0], i[1], i[2], i[2:0]}, (i == 0) ? 8'h00 : 8'h01 << (i - 1));
			st = {2'b00, val.overvoltage_reaction_select, val.desaturation_monitor_timing_select, |primary_err, 3'b000,
				val.opm == 3'h4, val.ready, 6'h00};
			rd(8'h01, i[0], 1'b1, st);
			wr(8'h01, 16'hFFFF);
			wr(8'h00, 16'hFFFF);
			rd(8'h01, i[1], 1'b1, st);
			rd(8'h00, i[2], 1'b1, {VER, 4'h0});
		end
		rd(8'h02, 1'b1, 1'b0, 16'h0000);
		rd(8'hFF, 1'b0, 1'b0, 16'h0000);
		report_and_stop();
	end
endmodule

/* File: rtl/pidsr_pkg.sv */
package pidsr_pkg;
	// register offsets, one 16-bit word per offset
	localparam logic [7:0] OFS_PRIMARY_IDENTIFICATION = 8'h00;
	localparam logic [7:0] OFS_PRIMARY_STATUS         = 8'h01;

	// identification word: version field sits in bits 15:4
	localparam int ID_VERS_LSB = 4;
	localparam int ID_VERS_MSB = 15;
	// status word field positions
	localparam int ST_OVR_BIT  = 13;
	localparam int ST_DESATURATION_MONITOR_BIT = 12;
	localparam int ST_ERR_BIT  = 11;
	localparam int ST_ACT_BIT  = 7;
	localparam int ST_RDY_BIT  = 6;
	// common trailer bits of every returned word
	localparam int LMR_BIT     = 1;
	localparam int PAR_BIT     = 0;

	// values after reset, plus the active mode code
	localparam logic [15:0] STATUS_RESET = 16'h0800;
	localparam logic [15:0] RDATA_RESET  = 16'h0000;
	localparam logic [2:0]  OPM_RESET    = 3'h0;
	localparam logic [2:0]  OPM_ACTIVE   = 3'h4;
	localparam logic [7:0]  ERR_RESET    = 8'hFF;

	// mirrored secondary-side state as received over the isolation link
	typedef struct packed {
		logic       overvoltage_reaction_select; // 0 class b, 1 class c
		logic       desaturation_monitor_timing_select;         // 0 set a, 1 set b
		logic       ready;                       // secondary chip ready
		logic [2:0] opm;                         // operating mode
	} pidsr_secondary_s;
endpackage

/* File: rtl/pidsr_regs.sv */
`timescale 1ns/1ps
module pidsr_regs #(
	parameter logic [11:0] CHIP_VERSION = 12'hA5C // arbitrary neutral version code
) (
	input  wire logic                       clk,           // 200 mhz clock
	input  wire logic                       resetn,        // async reset, active low
	input  wire logic                       rd_req,        // read strobe from spi frame logic
	input  wire logic                       wr_req,        // write strobe, ignored here
	input  wire logic [7:0]                 addr,          // word offset
	input  wire logic [15:0]                wdata,         // write data, ignored here
	input  wire logic                       msg_rejected,  // previous message discarded
	input  wire logic [7:0]                 primary_err,   // primary error register bits
	input  wire logic                       sec_valid,     // link delivered a new secondary update
	input  wire pidsr_pkg::pidsr_secondary_s sec_in,        // secondary state from link
	output logic                            rd_valid,      // read answer strobe
	output logic                            rd_hit,        // addressed register exists
	output logic                      [15:0] rdata          // read answer word
);
	pidsr_pkg::pidsr_secondary_s sec_reg;
	logic [7:0]  err_reg;
	logic [15:0] id_payload;
	logic [15:0] st_payload;
	logic [15:0] sel_payload;
	logic        hit;
	logic [15:0] word;
	logic [15:0] rdata_next;

	// mirrors update only from the link, never from a write; a missing update keeps the last value
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sec_reg <= '{1'b0, 1'b0, 1'b0, pidsr_pkg::OPM_RESET};
		end else if (sec_valid) begin
			sec_reg <= sec_in;
		end
	end

	// error summary sampled each cycle; reset value reads error set like the documented reset word
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			err_reg <= pidsr_pkg::ERR_RESET;
		end else begin
			err_reg <= primary_err;
		end
	end

	// payloads: everything not assigned stays zero
	always_comb begin
		id_payload = 16'h0000;
		id_payload[pidsr_pkg::ID_VERS_MSB:pidsr_pkg::ID_VERS_LSB] = CHIP_VERSION;
		st_payload = 16'h0000;
		st_payload[pidsr_pkg::ST_OVR_BIT]   = sec_reg.overvoltage_reaction_select;
		st_payload[pidsr_pkg::ST_DESATURATION_MONITOR_BIT] = sec_reg.desaturation_monitor_timing_select;
		st_payload[pidsr_pkg::ST_ERR_BIT]   = |err_reg;
		st_payload[pidsr_pkg::ST_ACT_BIT]   = (sec_reg.opm == pidsr_pkg::OPM_ACTIVE);
		st_payload[pidsr_pkg::ST_RDY_BIT]   = sec_reg.ready;
	end

	// word-wise decode, each offset one register
	always_comb begin
		hit = 1'b1;
		unique case (addr)
			pidsr_pkg::OFS_PRIMARY_IDENTIFICATION: sel_payload = id_payload;
			pidsr_pkg::OFS_PRIMARY_STATUS:         sel_payload = st_payload;
			default: begin
				sel_payload = 16'h0000;
				hit         = 1'b0;
			end
		endcase
	end

	pidsr_word_fmt u_fmt (
		.payload      (sel_payload),
		.msg_rejected (msg_rejected),
		.word         (word)
	);

	// answer registered one cycle after the read strobe; writes are dropped since all fields are read-only
	assign rdata_next = rd_req ? word : rdata;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rdata    <= pidsr_pkg::RDATA_RESET;
			rd_valid <= 1'b0;
			rd_hit   <= 1'b0;
		end else begin
			rdata    <= rdata_next;
			rd_valid <= rd_req;
			rd_hit   <= rd_req & hit;
		end
	end

	// checks on the registered answer word, plus the mirror taking a link update
	AST_ID_VERSION: assert property (@(posedge clk) disable iff (!resetn)
		rd_req && addr == pidsr_pkg::OFS_PRIMARY_IDENTIFICATION |=> rdata[15:4] == CHIP_VERSION && rdata[3:2] == 2'h0)
		else $error("identification version field wrong");

	AST_ST_ZERO: assert property (@(posedge clk) disable iff (!resetn)
		rd_req && addr == pidsr_pkg::OFS_PRIMARY_STATUS |=> rdata[15:14] == 2'h0 && rdata[10:8] == 3'h0
		&& rdata[5:2] == 4'h0)
		else $error("status reserved bits not zero");

	AST_LMR: assert property (@(posedge clk) disable iff (!resetn)
		rd_req |=> rdata[1] == $past(msg_rejected))
		else $error("rejected flag wrong");

	AST_PARITY: assert property (@(posedge clk) disable iff (!resetn)
		rd_valid |-> ^rdata == 1'b1)
		else $error("parity not odd");

	AST_OVR: assert property (@(posedge clk) disable iff (!resetn)
		sec_valid ##1 (rd_req && addr == pidsr_pkg::OFS_PRIMARY_STATUS && !sec_valid)
		|=> rdata[13] == $past(sec_in.overvoltage_reaction_select, 2))
		else $error("overvoltage mirror stale");

	AST_DESATURATION_MONITOR: assert property (@(posedge clk) disable iff (!resetn)
		rd_req && addr == pidsr_pkg::OFS_PRIMARY_STATUS |=> rdata[12] == $past(sec_reg.desaturation_monitor_timing_select))
		else $error("desaturation_monitor mirror wrong");

	// a read right after reset sees the shadow's reset pattern, not the input from two edges back
	AST_ERR: assert property (@(posedge clk) disable iff (!resetn)
		rd_req && addr == pidsr_pkg::OFS_PRIMARY_STATUS
		|=> rdata[11] == ($past(resetn, 2) ? |$past(primary_err, 2) : 1'b1))
		else $error("error summary wrong");

	AST_ACT: assert property (@(posedge clk) disable iff (!resetn)
		rd_req && addr == pidsr_pkg::OFS_PRIMARY_STATUS |=> rdata[7] == ($past(sec_reg.opm) == pidsr_pkg::OPM_ACTIVE))
		else $error("active flag wrong");

	AST_RDY: assert property (@(posedge clk) disable iff (!resetn)
		rd_req && addr == pidsr_pkg::OFS_PRIMARY_STATUS |=> rdata[6] == $past(sec_reg.ready))
		else $error("ready flag wrong");

	AST_HOLD: assert property (@(posedge clk) disable iff (!resetn)
		!rd_req |=> $stable(rdata))
		else $error("answer changed without read");

	AST_UNMAPPED: assert property (@(posedge clk) disable iff (!resetn)
		rd_req && addr > 8'h01 |=> !rd_hit && rdata[15:2] == 14'h0)
		else $error("unmapped offset answered");

	AST_TRACK: assert property (@(posedge clk) disable iff (!resetn)
		sec_valid |=> sec_reg == $past(sec_in))
		else $error("mirror not updated");

	// handshake timing: the answer strobe follows every read by exactly one edge
	AST_VALID_NEXT: assert property (@(posedge clk) disable iff (!resetn)
		rd_req |=> rd_valid)
		else $error("read not answered");

	AST_VALID_ONLY: assert property (@(posedge clk) disable iff (!resetn)
		!rd_req |=> !rd_valid)
		else $error("answer without read");

	AST_HIT_ID: assert property (@(posedge clk) disable iff (!resetn)
		rd_req && addr == pidsr_pkg::OFS_PRIMARY_IDENTIFICATION |=> rd_hit)
		else $error("identification offset missed");

	AST_HIT_ST: assert property (@(posedge clk) disable iff (!resetn)
		rd_req && addr == pidsr_pkg::OFS_PRIMARY_STATUS |=> rd_hit)
		else $error("status offset missed");

	AST_HIT_QUAL: assert property (@(posedge clk) disable iff (!resetn)
		!rd_valid |-> !rd_hit)
		else $error("hit without answer");

	// read-only behaviour: neither writes nor an idle link may move visible state; then error shadow, overvoltage and active flag checks
	AST_WR_IGNORED: assert property (@(posedge clk) disable iff (!resetn)
		wr_req && !rd_req |=> $stable(rdata))
		else $error("write changed answer");

	AST_MIRROR_HOLD: assert property (@(posedge clk) disable iff (!resetn)
		!sec_valid |=> $stable(sec_reg))
		else $error("mirror moved without update");

	AST_ERR_SHADOW: assert property (@(posedge clk) disable iff (!resetn)
		1'b1 |=> err_reg == $past(primary_err))
		else $error("error shadow lags");

	AST_OVR_DIRECT: assert property (@(posedge clk) disable iff (!resetn)
		rd_req && addr == pidsr_pkg::OFS_PRIMARY_STATUS |=> rdata[13] == $past(sec_reg.overvoltage_reaction_select))
		else $error("overvoltage mirror wrong");

	AST_ACT_CLEAR: assert property (@(posedge clk) disable iff (!resetn)
		rd_req && addr == pidsr_pkg::OFS_PRIMARY_STATUS && sec_reg.opm != pidsr_pkg::OPM_ACTIVE |=> !rdata[7])
		else $error("active flag set outside mode four");

	// combinational word checks, caught before the answer register hides the source
	AST_WORD_PARITY: assert property (@(posedge clk) disable iff (!resetn)
		rd_req |-> ^word == 1'b1)
		else $error("formatted word parity not odd");

	AST_WORD_LMR: assert property (@(posedge clk) disable iff (!resetn)
		rd_req |-> word[1] == msg_rejected)
		else $error("formatted rejected flag wrong");

	AST_ID_PAYLOAD: assert property (@(posedge clk) disable iff (!resetn)
		rd_req && addr == pidsr_pkg::OFS_PRIMARY_IDENTIFICATION |-> word[15:2] == {CHIP_VERSION, 2'h0})
		else $error("identification payload wrong");

	AST_ST_PAYLOAD_ZERO: assert property (@(posedge clk) disable iff (!resetn)
		rd_req && addr == pidsr_pkg::OFS_PRIMARY_STATUS |-> word[15:14] == 2'h0 && word[10:8] == 3'h0
		&& word[5:2] == 4'h0)
		else $error("status payload reserved bits set");

	// scenarios worth seeing at least once
	COV_ID_READ: cover property (@(posedge clk) rd_req && addr == pidsr_pkg::OFS_PRIMARY_IDENTIFICATION);
	COV_STATUS_READ: cover property (@(posedge clk) rd_req && addr == pidsr_pkg::OFS_PRIMARY_STATUS);
	COV_ACTIVE: cover property (@(posedge clk) rd_valid && rdata[7]);
	COV_REJECT: cover property (@(posedge clk) rd_valid && rdata[1]);
	COV_WRITE: cover property (@(posedge clk) wr_req && addr == pidsr_pkg::OFS_PRIMARY_STATUS && wdata != 16'h0);
endmodule

/* File: rtl/pidsr_word_fmt.sv */
`timescale 1ns/1ps
// builds a returned word: payload in 15:2, rejected flag, odd parity
module pidsr_word_fmt (
	input  wire logic [15:0] payload,      // bits 15:2 used, 1:0 ignored
	input  wire logic        msg_rejected, // previous message discarded
	output logic      [15:0] word          // formatted word
);
	logic [15:0] body;

	// parity bit makes the total count of ones odd
	always_comb begin
		body = {payload[15:2], msg_rejected, 1'b0};
		word = {body[15:1], ~(^body[15:1])};
	end
endmodule
